// ===== common/svd_pkg.sv
// Shared constants for the supply voltage detect control block.
// Assumes a 50 MHz APB clock and a 12-bit byte address from the bus fabric.
package svd_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned SVD_AW         = 12;        // APB address width
	localparam logic [11:0] SVD_CTRL_OFS   = 12'h000;   // Control word
	localparam logic [11:0] SVD_STAT_OFS   = 12'h004;   // Status word

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int unsigned SVD_C_DETECT   = 7;         // Detection enable
	localparam int unsigned SVD_C_SEL      = 3;         // Threshold select
	localparam int unsigned SVD_C_RSTEN    = 2;         // Reset enable
	localparam int unsigned SVD_C_FALLEN   = 1;         // Fall irq enable
	localparam int unsigned SVD_C_RISEEN   = 0;         // Rise irq enable
	localparam logic [2:0]  SVD_C_RSVD     = 3'h7;      // Bits 6..4 read 1

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int unsigned SVD_S_FALL     = 1;         // Fall flag
	localparam int unsigned SVD_S_RISE     = 0;         // Rise flag
	localparam logic [5:0]  SVD_S_RSVD     = 6'h3F;     // Bits 7..2 read 1

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic        SVD_BIT_RST    = 1'h0;      // Enables and flags
	localparam logic        SVD_LEVEL_RST  = 1'h1;      // Irq level idles 1

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned SVD_CLK_NS     = 20;        // pclk period
	localparam int unsigned SVD_FILT_NS    = 100;       // Pin noise filter
	localparam int unsigned SVD_FILT_CYC   =
		(SVD_FILT_NS + SVD_CLK_NS - 1) / SVD_CLK_NS; // Rounded up
	localparam logic [2:0]  SVD_FILT_LAST  = 3'(SVD_FILT_CYC - 1);
	localparam int unsigned SVD_RELEASE    = 131072;    // Prescaler cycles
	localparam int unsigned SVD_PRESC_W    = 18;        // Prescaler width
	localparam int unsigned SVD_SYNC_N     = 4;         // Synced inputs

	// ----------------------------------------------------------------
	// Supply tracking states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SVD_STANDBY = 4'h1,    // Detection off
		SVD_ABOVE   = 4'h2,    // Supply above fall threshold
		SVD_FELL    = 4'h4,    // Dropped below fall threshold
		SVD_SPENT   = 4'h8     // Dropped below reset threshold too
	} svd_state_t;

endpackage

// ===== logic/svd_input_sync.sv
// Three-stage synchroniser for the asynchronous comparator and pin inputs.
// Assumes inputs are levels from outside the pclk domain.
module svd_input_sync (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [3:0]  async_in,
	output logic      [3:0]  sync_out
);

	// ----------------------------------------------------------------
	// One chain per input
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < svd_pkg::SVD_SYNC_N; g++) begin : gen_bit
			logic s1;    // First stage, read by s2 only
			logic s2;    // Second stage
			logic s3;    // Third stage
			logic held;  // Agreed level, one driver per bit

			// Shift chain; output follows once stages two and three agree
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1   <= 1'h0;
					s2   <= 1'h0;
					s3   <= 1'h0;
					held <= 1'h0;
				end else begin
					s1 <= async_in[g];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						held <= s3;
					end
				end
			end

			assign sync_out[g] = held;
		end
	endgenerate

endmodule

// ===== logic/svd_ctrl.sv
// Supply voltage detect control: status flags, interrupt and reset release.
// Assumes analog comparators outside, APB master, power-on reset on presetn.
//
// How it works
// - Status bits 7..2 read one, ignore writes
// - Fall comparator sets the fall flag
// - Flag clears by zero write after reading one
// - Rise flag after armed fall then rise
// - Pin low holds prescaler; release after count
// - Pin glitches under 100 ns are filtered
// - Functions idle after power-on until enabled
// - Below reset threshold drives reset low
// - Supply recovery counts prescaler then releases
// - Low-voltage reset keeps detect, select, reset-enable
// - Fall drives irq level low, sets flag
// - Fall with enable raises line zero
// - Rise sets level, flag and line zero
// - Control bit layout with reserved ones
// - Detect, select, reset-enable survive low-voltage reset
//
// The APB register port and the register offsets were left to the implementer.
module svd_ctrl #(
	parameter int unsigned RELEASE_CYCLES = svd_pkg::SVD_RELEASE
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        reset_pin,
	input  wire logic        cmp_below_fall,
	input  wire logic        cmp_above_rise,
	input  wire logic        cmp_below_reset,
	input  wire logic        wdt_reset,
	output logic             detect_enable,
	output logic             reset_threshold_select,
	output logic             lowvolt_reset_n,
	output logic             lowvolt_irq_level,
	output logic             ext_irq_line0,
	output logic             prescaler_overflow,
	output logic             chip_reset_n
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam logic [17:0] PRESC_LAST = 18'(RELEASE_CYCLES - 1);

	logic [3:0]  sync_in;              // Synchronised inputs
	logic        pin_s;                // Synchronised pin level
	logic        below_fall;           // Synchronised fall comparator
	logic        above_rise;           // Synchronised rise comparator
	logic        below_reset;          // Synchronised reset comparator
	logic        pin_filt;             // Filtered pin level
	logic [2:0]  filt_cnt;             // Cycles pin differs from filtered
	logic        lowvolt_reset_enable; // Control bit 2
	logic        fall_irq_enable;      // Control bit 1
	logic        rise_irq_enable;      // Control bit 0
	logic        supply_fall_flag;     // Status bit 1
	logic        supply_rise_flag;     // Status bit 0
	logic        seen_fall;            // Fall flag read as one
	logic        seen_rise;            // Rise flag read as one
	logic        rise_armed;           // Rise enable held at fall time
	svd_pkg::svd_state_t state;        // Supply tracking state
	svd_pkg::svd_state_t next_state;   // Next tracking state
	logic [17:0] presc;                // Release prescaler
	logic [31:0] next_prdata;          // Read mux output

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	wire setup_phase = psel & ~penable;
	wire access      = psel & penable;
	wire hit_ctrl    = (paddr == svd_pkg::SVD_CTRL_OFS);
	wire hit_stat    = (paddr == svd_pkg::SVD_STAT_OFS);
	wire wr_ctrl     = access & pwrite & hit_ctrl;
	wire wr_stat     = access & pwrite & hit_stat;
	wire rd_stat     = access & ~pwrite & hit_stat;
	wire pin_hold    = ~pin_filt | wdt_reset;             // Chip reset source
	wire lv_active   = detect_enable & lowvolt_reset_enable
		& below_reset;
	wire presc_hold  = pin_hold | lv_active;
	wire presc_done  = (presc == PRESC_LAST);
	wire fall_event  = (state == svd_pkg::SVD_ABOVE) & below_fall;
	wire rise_event  = (state == svd_pkg::SVD_FELL) & above_rise
		& ~below_reset;
	wire set_fall    = fall_event;
	wire set_rise    = rise_event & rise_armed & rise_irq_enable;

	// Zero written to a flag that was read as one
	function automatic logic clr_req(input logic wr, input logic seen,
		input logic wbit);
		clr_req = wr & seen & ~wbit;
	endfunction

	wire clr_fall = clr_req(wr_stat, seen_fall,
		pwdata[svd_pkg::SVD_S_FALL]);
	wire clr_rise = clr_req(wr_stat, seen_rise,
		pwdata[svd_pkg::SVD_S_RISE]);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	svd_input_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({cmp_below_reset, cmp_above_rise, cmp_below_fall,
			reset_pin}),
		.sync_out (sync_in)
	);

	assign pin_s       = sync_in[0];
	assign below_fall  = sync_in[1];
	assign above_rise  = sync_in[2];
	assign below_reset = sync_in[3];

	// ----------------------------------------------------------------
	// Reset pin noise filter
	// ----------------------------------------------------------------
	// Adopt new pin level only after it stands for the filter time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_filt <= 1'h0;
			filt_cnt <= 3'h0;
		end else if (pin_s == pin_filt) begin
			filt_cnt <= 3'h0;               // Glitch ended, restart
		end else if (filt_cnt == svd_pkg::SVD_FILT_LAST) begin
			pin_filt <= pin_s;
			filt_cnt <= 3'h0;
		end else begin
			filt_cnt <= filt_cnt + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// Detect, select and reset enable: cleared by pin or watchdog only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detect_enable          <= svd_pkg::SVD_BIT_RST;
			reset_threshold_select <= svd_pkg::SVD_BIT_RST;
			lowvolt_reset_enable   <= svd_pkg::SVD_BIT_RST;
		end else if (pin_hold) begin
			detect_enable          <= svd_pkg::SVD_BIT_RST;
			reset_threshold_select <= svd_pkg::SVD_BIT_RST;
			lowvolt_reset_enable   <= svd_pkg::SVD_BIT_RST;
		end else if (wr_ctrl) begin
			// A low-voltage reset does not touch these bits
			detect_enable          <= pwdata[svd_pkg::SVD_C_DETECT];
			reset_threshold_select <= pwdata[svd_pkg::SVD_C_SEL];
			lowvolt_reset_enable   <= pwdata[svd_pkg::SVD_C_RSTEN];
		end
	end

	// Interrupt enables: also cleared by a low-voltage reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fall_irq_enable <= svd_pkg::SVD_BIT_RST;
			rise_irq_enable <= svd_pkg::SVD_BIT_RST;
		end else if (pin_hold | lv_active) begin
			fall_irq_enable <= svd_pkg::SVD_BIT_RST;
			rise_irq_enable <= svd_pkg::SVD_BIT_RST;
		end else if (wr_ctrl) begin
			fall_irq_enable <= pwdata[svd_pkg::SVD_C_FALLEN];
			rise_irq_enable <= pwdata[svd_pkg::SVD_C_RISEEN];
		end
	end

	// ----------------------------------------------------------------
	// Supply tracking state machine
	// ----------------------------------------------------------------
	// Next state from comparators; detection off forces standby
	always_comb begin
		next_state = state;
		case (state)
			svd_pkg::SVD_STANDBY: begin
				if (detect_enable) begin
					next_state = svd_pkg::SVD_ABOVE;
				end
			end
			svd_pkg::SVD_ABOVE: begin
				if (below_fall) begin
					next_state = svd_pkg::SVD_FELL;
				end
			end
			svd_pkg::SVD_FELL: begin
				if (below_reset) begin
					next_state = svd_pkg::SVD_SPENT;  // No rise flag now
				end else if (above_rise) begin
					next_state = svd_pkg::SVD_ABOVE;
				end
			end
			svd_pkg::SVD_SPENT: begin
				if (above_rise) begin
					next_state = svd_pkg::SVD_ABOVE;
				end
			end
			default: begin
				next_state = svd_pkg::SVD_STANDBY;
			end
		endcase
		if (!detect_enable) begin
			next_state = svd_pkg::SVD_STANDBY;
		end
	end

	// State register, cleared by chip or low-voltage reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= svd_pkg::SVD_STANDBY;
		end else if (pin_hold | lv_active) begin
			state <= svd_pkg::SVD_STANDBY;
		end else begin
			state <= next_state;
		end
	end

	// Irq level follows fall and valid rise events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lowvolt_irq_level <= svd_pkg::SVD_LEVEL_RST;
			rise_armed        <= 1'h0;
		end else if (next_state == svd_pkg::SVD_STANDBY) begin
			lowvolt_irq_level <= svd_pkg::SVD_LEVEL_RST;
			rise_armed        <= 1'h0;
		end else if (fall_event) begin
			lowvolt_irq_level <= 1'h0;
			rise_armed        <= rise_irq_enable;
		end else if (rise_event) begin
			lowvolt_irq_level <= 1'h1;
			rise_armed        <= 1'h0;
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_fall_flag <= svd_pkg::SVD_BIT_RST;
			supply_rise_flag <= svd_pkg::SVD_BIT_RST;
		end else if (pin_hold | lv_active) begin
			supply_fall_flag <= svd_pkg::SVD_BIT_RST;
			supply_rise_flag <= svd_pkg::SVD_BIT_RST;
		end else begin
			if (set_fall) begin
				supply_fall_flag <= 1'h1;
			end else if (clr_fall) begin
				supply_fall_flag <= 1'h0;
			end
			if (set_rise) begin
				supply_rise_flag <= 1'h1;
			end else if (clr_rise) begin
				supply_rise_flag <= 1'h0;
			end
		end
	end

	// Remember flags read as one until the next status write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_fall <= 1'h0;
			seen_rise <= 1'h0;
		end else if (wr_stat | pin_hold | lv_active) begin
			seen_fall <= 1'h0;
			seen_rise <= 1'h0;
		end else if (rd_stat) begin
			seen_fall <= seen_fall | supply_fall_flag;
			seen_rise <= seen_rise | supply_rise_flag;
		end
	end

	// Interrupt request in the cycle a flag first shows
	assign ext_irq_line0 = (supply_fall_flag & fall_irq_enable)
		| (supply_rise_flag & rise_irq_enable);

	// ----------------------------------------------------------------
	// Release prescaler and internal resets
	// ----------------------------------------------------------------
	// Count from release of the hold, stop at overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc <= 18'h00000;
		end else if (presc_hold) begin
			presc <= 18'h00000;
		end else if (!presc_done) begin
			presc <= presc + 18'h00001;
		end
	end

	// Chip reset releases on overflow; low-voltage reset is registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_reset_n       <= 1'h0;
			prescaler_overflow <= 1'h0;
			lowvolt_reset_n    <= 1'h1;
		end else begin
			lowvolt_reset_n    <= ~lv_active;
			prescaler_overflow <= presc_done & ~presc_hold
				& ~chip_reset_n;
			if (presc_hold) begin
				chip_reset_n <= 1'h0;
			end else if (presc_done) begin
				chip_reset_n <= 1'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Read mux, captured in setup so data stands through access
	always_comb begin
		next_prdata = 32'h00000000;
		if (hit_ctrl) begin
			next_prdata[7:0] = {detect_enable, svd_pkg::SVD_C_RSVD,
				reset_threshold_select, lowvolt_reset_enable,
				fall_irq_enable, rise_irq_enable};
		end else if (hit_stat) begin
			next_prdata[7:0] = {svd_pkg::SVD_S_RSVD,
				supply_fall_flag, supply_rise_flag};
		end
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup_phase) begin
			prdata <= next_prdata;
		end
	end

	// Zero wait states; unmapped address answers with an error
	assign pready  = 1'h1;
	assign pslverr = access & ~hit_ctrl & ~hit_stat;

endmodule

// ===== verif/svd_supply_model.sv
// Behavioural supply comparators standing at the analog side of the block.
// Assumes the bench sets the supply level in millivolts.
module svd_supply_model #(
	parameter int unsigned FALL_MV   = 3700, // Fall threshold
	parameter int unsigned RISE_MV   = 4000, // Rise threshold
	parameter int unsigned RST_LO_MV = 2300, // Low reset threshold
	parameter int unsigned RST_HI_MV = 3600  // High reset threshold
) (
	input  wire logic [15:0] supply_mv,
	input  wire logic        reset_threshold_select,
	output logic             cmp_below_fall,
	output logic             cmp_above_rise,
	output logic             cmp_below_reset
);
	// ------------------------------------------------------------
	// Comparators
	// ------------------------------------------------------------
	wire logic [15:0] rst_mv; // Selected reset threshold
	assign rst_mv = reset_threshold_select ? 16'(RST_HI_MV) : 16'(RST_LO_MV);
	assign cmp_below_fall  = supply_mv < 16'(FALL_MV);
	assign cmp_above_rise  = supply_mv > 16'(RISE_MV);
	assign cmp_below_reset = supply_mv < rst_mv;
endmodule

// ===== verif/svd_ctrl_assertions.sv
// Concurrent checks on the ports of the supply detect control block.
// Assumes one pclk domain and a bind into svd_ctrl.
module svd_ctrl_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        reset_pin,
	input wire logic        cmp_below_fall,
	input wire logic        cmp_above_rise,
	input wire logic        cmp_below_reset,
	input wire logic        wdt_reset,
	input wire logic        detect_enable,
	input wire logic        reset_threshold_select,
	input wire logic        lowvolt_reset_n,
	input wire logic        lowvolt_irq_level,
	input wire logic        ext_irq_line0,
	input wire logic        prescaler_overflow,
	input wire logic        chip_reset_n
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic rd_acc; // Read access phase
	assign rd_acc = psel && penable && !pwrite;
	// Chip stays in reset for the first 8 cycles of the prescaler count
	sequence s_held;
		!chip_reset_n [*8];
	endsequence
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_stat_reserved: assert property (rd_acc && paddr == svd_pkg::SVD_STAT_OFS
		|-> prdata[7:2] == 6'h3F) else $error("status reserved bits");
	a_ctrl_reserved: assert property (rd_acc && paddr == svd_pkg::SVD_CTRL_OFS
		|-> prdata[6:4] == 3'h7 && prdata[31:8] == 24'h0)
		else $error("control reserved bits");
	a_fall_cause: assert property ($fell(lowvolt_irq_level)
		|-> detect_enable && $past(cmp_below_fall, 4))
		else $error("irq level fell without fall");
	a_rise_cause: assert property ($rose(lowvolt_irq_level) && lowvolt_reset_n
		&& chip_reset_n && detect_enable |-> $past(cmp_above_rise, 4))
		else $error("irq level rose without rise");
	a_lv_cause: assert property ($fell(lowvolt_reset_n)
		|-> detect_enable && $past(cmp_below_reset, 4))
		else $error("low-voltage reset without cause");
	a_lv_hold: assert property (!lowvolt_reset_n |=> !chip_reset_n)
		else $error("chip left reset during low voltage");
	a_lv_keeps: assert property (!lowvolt_reset_n && !$past(lowvolt_reset_n)
		|-> $stable(detect_enable) && $stable(reset_threshold_select))
		else $error("control bits lost in low voltage");
	a_release_wait: assert property ($rose(lowvolt_reset_n) |-> s_held)
		else $error("chip released before count");
	a_ovf_release: assert property (prescaler_overflow
		|-> chip_reset_n && !$past(chip_reset_n))
		else $error("overflow apart from release");
	a_ovf_pulse: assert property (prescaler_overflow |=> !prescaler_overflow)
		else $error("overflow longer than a cycle");
	a_pin_filter: assert property ($fell(chip_reset_n) && !cmp_below_reset
		&& !$past(wdt_reset)
		|-> !$past(reset_pin, 5) && !$past(reset_pin, 6))
		else $error("reset from a short pin pulse");
	a_standby: assert property (!$past(presetn)
		|-> !detect_enable && lowvolt_irq_level && !ext_irq_line0)
		else $error("functions active after power-on");
endmodule

bind svd_ctrl svd_ctrl_assertions i_svd_ctrl_assertions (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .reset_pin(reset_pin),
	.cmp_below_fall(cmp_below_fall), .cmp_above_rise(cmp_above_rise),
	.cmp_below_reset(cmp_below_reset), .detect_enable(detect_enable),
	.reset_threshold_select(reset_threshold_select), .wdt_reset(wdt_reset),
	.lowvolt_reset_n(lowvolt_reset_n), .lowvolt_irq_level(lowvolt_irq_level),
	.ext_irq_line0(ext_irq_line0), .prescaler_overflow(prescaler_overflow),
	.chip_reset_n(chip_reset_n));

// ===== verif/svd_ctrl_tb.sv
// Self-checking bench for the supply detect control block over APB.
// Assumes the supply model on the comparators; watchdog pulsed once.
module svd_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int unsigned REL = 16;               // Short prescaler count
	localparam logic [11:0] CT  = svd_pkg::SVD_CTRL_OFS;
	localparam logic [11:0] ST  = svd_pkg::SVD_STAT_OFS;
	logic        pclk      = 1'h0;
	logic        presetn   = 1'h0;
	logic        psel      = 1'h0;
	logic        penable   = 1'h0;
	logic        pwrite    = 1'h0;
	logic        reset_pin = 1'h0;                 // Pin held low at power-on
	logic        wdt_reset = 1'h0;                 // Watchdog request
	logic [11:0] paddr     = 12'h000;
	logic [31:0] pwdata    = 32'h0;
	logic [15:0] supply_mv = 16'h1388;             // 5000 mV
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, rerr, detect_enable, reset_threshold_select;
	logic        lowvolt_reset_n, lowvolt_irq_level, ext_irq_line0;
	logic        prescaler_overflow, chip_reset_n;
	logic        cmp_below_fall, cmp_above_rise, cmp_below_reset;
	int          num_errors, comparisons, cycles, n;
	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	svd_ctrl #(.RELEASE_CYCLES(REL)) i_svd_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reset_pin(reset_pin),
		.cmp_below_fall(cmp_below_fall), .cmp_above_rise(cmp_above_rise),
		.cmp_below_reset(cmp_below_reset), .wdt_reset(wdt_reset),
		.detect_enable(detect_enable),
		.reset_threshold_select(reset_threshold_select),
		.lowvolt_reset_n(lowvolt_reset_n),
		.lowvolt_irq_level(lowvolt_irq_level), .ext_irq_line0(ext_irq_line0),
		.prescaler_overflow(prescaler_overflow), .chip_reset_n(chip_reset_n));
	svd_supply_model i_svd_supply_model (
		.supply_mv(supply_mv), .reset_threshold_select(reset_threshold_select),
		.cmp_below_fall(cmp_below_fall), .cmp_above_rise(cmp_above_rise),
		.cmp_below_reset(cmp_below_reset));
	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			num_errors++;
			summarize();
		end
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; answer taken at the edge pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) begin
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic wait_for(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < REL + 100) begin
			@(posedge pclk);
			n++;
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		wait_for(chip_reset_n, 1'h1);
		chk(32'(n >= REL && n <= REL + 12), 32'h1);
		chk(32'(prescaler_overflow), 32'h1);
		rd(CT, 32'h70);
		rd(ST, 32'hFC);
		chk(32'(lowvolt_irq_level), 32'h1);
		rd(12'h008, 32'h0);
		chk(32'(rerr), 32'h1);
		apb(1'h1, ST, 32'h00);
		rd(ST, 32'hFC);
		$display("test reset done");
	endtask
	task automatic t_fall();
		apb(1'h1, CT, 32'h80);
		cyc(2500);
		rd(ST, 32'hFC);
		apb(1'h1, ST, 32'hFC);
		apb(1'h1, CT, 32'h83);
		rd(CT, 32'hF3);
		supply_mv <= 16'h0DAC; // 3500 mV
		cyc(10);
		chk(32'(lowvolt_irq_level), 32'h0);
		chk(32'(ext_irq_line0), 32'h1);
		rd(ST, 32'hFE);
		apb(1'h1, ST, 32'hFF);
		apb(1'h1, ST, 32'hFD);
		rd(ST, 32'hFE);
		apb(1'h1, ST, 32'hFD);
		rd(ST, 32'hFC);
		chk(32'(ext_irq_line0), 32'h0);
		$display("test fall done");
	endtask
	task automatic t_rise();
		supply_mv <= 16'h1194; // 4500 mV
		cyc(10);
		chk(32'(lowvolt_irq_level), 32'h1);
		chk(32'(ext_irq_line0), 32'h1);
		rd(ST, 32'hFD);
		apb(1'h1, ST, 32'hFC);
		rd(ST, 32'hFC);
		$display("test rise done");
	endtask
	task automatic t_lvr();
		apb(1'h1, CT, 32'h8F);
		supply_mv <= 16'h07D0; // 2000 mV
		wait_for(lowvolt_reset_n, 1'h0);
		chk(32'(n <= 10), 32'h1);
		cyc(2);
		chk(32'(chip_reset_n), 32'h0);
		supply_mv <= 16'h1194;
		wait_for(chip_reset_n, 1'h1);
		chk(32'(n >= REL && n <= REL + 12), 32'h1);
		rd(CT, 32'hFC);
		chk(32'(reset_threshold_select), 32'h1);
		rd(ST, 32'hFC);
		apb(1'h1, CT, 32'hF8);
		apb(1'h1, CT, 32'h00);
		rd(CT, 32'h70);
		$display("test low-voltage reset done");
	endtask
	task automatic t_pin();
		apb(1'h1, CT, 32'h80);
		reset_pin <= 1'h0;
		cyc(3);
		reset_pin <= 1'h1;
		cyc(20);
		chk(32'(chip_reset_n), 32'h1);
		reset_pin <= 1'h0;
		cyc(14);
		chk(32'(chip_reset_n), 32'h0);
		reset_pin <= 1'h1;
		wait_for(chip_reset_n, 1'h1);
		chk(32'(n >= REL && n <= REL + 12), 32'h1);
		rd(CT, 32'h70);
		apb(1'h1, CT, 32'h88);
		wdt_reset <= 1'h1;
		cyc(1);
		wdt_reset <= 1'h0;
		cyc(1);
		chk(32'(chip_reset_n), 32'h0);
		wait_for(chip_reset_n, 1'h1);
		chk(32'(n >= REL - 2 && n <= REL + 12), 32'h1);
		rd(CT, 32'h70);
		$display("test reset pin done");
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn   <= 1'h1;
		reset_pin <= 1'h1;
		t_reset();
		t_fall();
		t_rise();
		t_lvr();
		t_pin();
		summarize();
	end
endmodule
